// >>> ovf_fault_response.sv
`timescale 1ns/100ps
`include "ovf_cfg.svh"

// Notes on behaviour
// - A 16-bit unsigned over-voltage threshold in the output-voltage format defines the fault level.
// - Response 00 keeps the output regulating with no interruption on a fault.
// - Response 01 runs on for the coded delay and then applies the retry setting if the fault remains.
// - Response 10 disables the output at once and then follows the retry count.
// - Response 11 holds the output off only while the fault lasts and re-enables it afterwards.
// - A retry count of 000 leaves the output off until the latched fault is cleared.
// - A latched fault clears on an individual status clear, a clear-all command or a reset.
// - A latched fault also clears when the output is commanded off and then on again.
// - Retry count 111 retries without limit; counts 001 to 110 give that many attempts.
// - Delay codes 0 to 4 give 1, 2, 4, 8 and 16 delay units for run-on or restart spacing.

module ovf_fault_response
    import ovf_pkg::*;
#(
    parameter logic [15:0] UNIT_CYCLES = 16'(`OVF_DELAY_UNIT_CYC)
) (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic cmd_wr_in,
    input wire logic cmd_rd_in,
    input wire logic [7:0] cmd_code_in,
    input wire logic [15:0] cmd_data_in,
    input wire logic [15:0] vout_meas_in,
    input wire logic output_on_in,
    input wire logic status_clear_in,
    input wire logic clear_faults_in,
    output logic [15:0] rd_data_out,
    output logic output_enable_out,
    output logic fault_latched_out
);

    ////////////////////////////////////////////////////////////////////////////////
    ovf_regs_t r;
    ovf_regs_t next_r;
    logic ov;
    logic clear;
    logic timer_start;
    logic timer_expired;
    logic [1:0] resp;
    logic [2:0] retries;
    logic [2:0] delay_code;
    logic retries_used;

    assign resp = r.react[`OVF_RESP_HI:`OVF_RESP_LO];
    assign retries = r.react[`OVF_RETRY_HI:`OVF_RETRY_LO];
    assign delay_code = r.react[`OVF_DELAY_HI:`OVF_DELAY_LO];
    assign ov = vout_meas_in > r.thresh;
    assign clear = status_clear_in | clear_faults_in | (output_on_in & ~r.on_q);
    assign retries_used = (retries != `OVF_RETRY_ENDLESS) && (r.tries >= retries);

    ovf_delay_timer #(
        .UNIT_CYCLES(UNIT_CYCLES)
    ) u_timer (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .start_in(timer_start),
        .code_in(delay_code),
        .expired_out(timer_expired)
    );

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_r = r;
        timer_start = 1'b0;
        next_r.on_q = output_on_in;

        if (cmd_wr_in && cmd_code_in == `OVF_CMD_THRESHOLD) begin
            next_r.thresh = cmd_data_in;
        end
        if (cmd_wr_in && cmd_code_in == `OVF_CMD_REACTION) begin
            next_r.react = cmd_data_in[7:0];
        end
        if (cmd_rd_in) begin
            if (cmd_code_in == `OVF_CMD_THRESHOLD) begin
                next_r.rd = r.thresh;
            end else if (cmd_code_in == `OVF_CMD_REACTION) begin
                next_r.rd = {8'h00, r.react};
            end else begin
                next_r.rd = 16'h0000;
            end
        end

        if (clear) begin
            // A fault present in the clearing cycle latches again, so the event is never lost.
            next_r.latched = ov && (resp != `OVF_RESP_IGNORE);
            next_r.tries = 3'h0;
            next_r.st = OVF_RUN;
        end else begin
            unique case (r.st)
                OVF_RUN: begin
                    if (ov && resp == `OVF_RESP_RUNON) begin
                        next_r.latched = 1'b1;
                        next_r.st = OVF_RUNON;
                        timer_start = 1'b1;
                    end else if (ov && resp == `OVF_RESP_SHUTDOWN) begin
                        next_r.latched = 1'b1;
                        if (retries == `OVF_RETRY_NONE || retries_used) begin
                            next_r.st = OVF_LATCHED;
                        end else begin
                            next_r.st = OVF_WAIT;
                            timer_start = 1'b1;
                        end
                    end else if (ov && resp == `OVF_RESP_HOLDOFF) begin
                        next_r.latched = 1'b1;
                        next_r.st = OVF_HOLD;
                    end else if (!ov && r.tries != 3'h0 && timer_expired) begin
                        // A restart that stays fault free for one delay counts as a success.
                        next_r.tries = 3'h0;
                    end
                end
                OVF_RUNON: begin
                    if (timer_expired) begin
                        if (!ov) begin
                            next_r.st = OVF_RUN;
                        end else if (retries == `OVF_RETRY_NONE || retries_used) begin
                            next_r.st = OVF_LATCHED;
                        end else begin
                            next_r.st = OVF_WAIT;
                            timer_start = 1'b1;
                        end
                    end
                end
                OVF_WAIT: begin
                    if (timer_expired) begin
                        if (retries != `OVF_RETRY_ENDLESS) begin
                            next_r.tries = r.tries + 3'h1;
                        end
                        next_r.st = OVF_RUN;
                        timer_start = 1'b1;
                    end
                end
                OVF_HOLD: begin
                    if (!ov) begin
                        next_r.st = OVF_RUN;
                    end
                end
                OVF_LATCHED: begin
                    next_r.st = OVF_LATCHED;
                end
                default: begin
                    next_r.st = OVF_LATCHED;
                end
            endcase
        end

        // The output only runs while commanded on and not in an off state of the response.
        next_r.out_en = output_on_in && (next_r.st == OVF_RUN || next_r.st == OVF_RUNON);
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            r <= '{st: OVF_RUN, thresh: `OVF_THRESHOLD_RST, react: `OVF_REACTION_RST, tries: 3'h0,
                   latched: 1'b0, out_en: 1'b0, on_q: 1'b0, rd: 16'h0000};
        end else begin
            r <= next_r;
        end
    end

    assign rd_data_out = r.rd;
    assign output_enable_out = r.out_en;
    assign fault_latched_out = r.latched;

    ////////////////////////////////////////////////////////////////////////////////
    default clocking @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);

    sequence s_run_fault(logic [1:0] code);
        r.st == OVF_RUN && ov && resp == code && !clear;
    endsequence

    a_threshold_write: assert property (cmd_wr_in && cmd_code_in == `OVF_CMD_THRESHOLD |=>
        r.thresh == $past(cmd_data_in))
        else $error("Threshold write not stored.");
    a_ignore_stays_on: assert property (s_run_fault(`OVF_RESP_IGNORE) && output_on_in |=>
        output_enable_out && r.st == OVF_RUN)
        else $error("Ignored fault interrupted the output.");
    a_runon_keeps_on: assert property (s_run_fault(`OVF_RESP_RUNON) && output_on_in |=>
        output_enable_out && r.st == OVF_RUNON)
        else $error("Run-on response did not keep the output running.");
    a_shutdown_now: assert property (s_run_fault(`OVF_RESP_SHUTDOWN) |=>
        !output_enable_out && fault_latched_out)
        else $error("Shutdown response left the output on.");
    a_hold_release: assert property (r.st == OVF_HOLD && !ov && !clear && output_on_in |=>
        r.st == OVF_RUN && output_enable_out)
        else $error("Hold-off did not release after the fault went away.");
    a_no_retry_latch: assert property (s_run_fault(`OVF_RESP_SHUTDOWN) && retries == `OVF_RETRY_NONE |=>
        r.st == OVF_LATCHED)
        else $error("Zero retry count did not latch the output off.");
    a_status_clear: assert property (status_clear_in && !ov |=> !fault_latched_out && r.st == OVF_RUN)
        else $error("Status clear did not release the latched fault.");
    a_onoff_clear: assert property (!r.on_q && output_on_in && !ov |=> r.st == OVF_RUN && !fault_latched_out)
        else $error("Off then on did not clear the latched fault.");
    a_endless_retry: assert property (r.st == OVF_WAIT && retries == `OVF_RETRY_ENDLESS && !clear |=>
        r.st != OVF_LATCHED && r.tries == $past(r.tries))
        else $error("Endless retry counted or latched.");
    a_exhausted_latch: assert property (s_run_fault(`OVF_RESP_SHUTDOWN) && retries != `OVF_RETRY_NONE &&
        retries != `OVF_RETRY_ENDLESS && r.tries >= retries |=> r.st == OVF_LATCHED)
        else $error("Used-up retries did not latch the output off.");
    a_fault_compare: assert property (r.st == OVF_RUN && resp == `OVF_RESP_HOLDOFF && !clear &&
        vout_meas_in > r.thresh |=> r.st == OVF_HOLD)
        else $error("Over-voltage compare did not trip the hold-off.");

endmodule

// >>> ovf_cfg.svh
`ifndef OVF_CFG_SVH
`define OVF_CFG_SVH

// Command codes of the two settings.
`define OVF_CMD_THRESHOLD 8'h40
`define OVF_CMD_REACTION 8'h41

// Fields of the reaction byte.
`define OVF_RESP_HI 7
`define OVF_RESP_LO 6
`define OVF_RETRY_HI 5
`define OVF_RETRY_LO 3
`define OVF_DELAY_HI 2
`define OVF_DELAY_LO 0

// Field codes with a fixed meaning.
`define OVF_RESP_IGNORE 2'h0
`define OVF_RESP_RUNON 2'h1
`define OVF_RESP_SHUTDOWN 2'h2
`define OVF_RESP_HOLDOFF 2'h3
`define OVF_RETRY_NONE 3'h0
`define OVF_RETRY_ENDLESS 3'h7
`define OVF_DELAY_MAX_CODE 3'h4

// Reset values of the settings.
`define OVF_THRESHOLD_RST 16'hFFFF
`define OVF_REACTION_RST 8'h80

// Timing: one delay unit in microseconds, at a 25 MHz clock.
`define OVF_CLK_MHZ 25
`define OVF_DELAY_UNIT_US 10
`define OVF_DELAY_UNIT_CYC (`OVF_DELAY_UNIT_US * `OVF_CLK_MHZ)

`endif

// >>> ovf_pkg.sv
package ovf_pkg;

    typedef enum logic [2:0] {
        OVF_RUN = 3'b000,
        OVF_RUNON = 3'b001,
        OVF_WAIT = 3'b010,
        OVF_HOLD = 3'b011,
        OVF_LATCHED = 3'b100
    } ovf_state_t;

    typedef struct packed {
        ovf_state_t st;
        logic [15:0] thresh;
        logic [7:0] react;
        logic [2:0] tries;
        logic latched;
        logic out_en;
        logic on_q;
        logic [15:0] rd;
    } ovf_regs_t;

    typedef struct packed {
        logic [4:0] units;
        logic [15:0] pre;
        logic expired;
    } ovf_timer_t;

endpackage

// >>> ovf_delay_timer.sv
`timescale 1ns/100ps
`include "ovf_cfg.svh"

module ovf_delay_timer
    import ovf_pkg::*;
#(
    parameter logic [15:0] UNIT_CYCLES = 16'(`OVF_DELAY_UNIT_CYC)
) (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic start_in,
    input wire logic [2:0] code_in,
    output logic expired_out
);

    ovf_timer_t r;
    ovf_timer_t next_r;

    always_comb begin
        next_r = r;
        if (start_in) begin
            // Codes above the last defined one are clamped to the longest delay.
            if (code_in > `OVF_DELAY_MAX_CODE) begin
                next_r.units = 5'h10;
            end else begin
                next_r.units = 5'(5'h01 << code_in);
            end
            next_r.pre = UNIT_CYCLES - 16'h0001;
            next_r.expired = 1'b0;
        end else if (!r.expired) begin
            if (r.pre != 16'h0000) begin
                next_r.pre = r.pre - 16'h0001;
            end else if (r.units == 5'h01) begin
                next_r.expired = 1'b1;
            end else begin
                next_r.units = r.units - 5'h01;
                next_r.pre = UNIT_CYCLES - 16'h0001;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            r <= '{units: 5'h00, pre: 16'h0000, expired: 1'b1};
        end else begin
            r <= next_r;
        end
    end

    assign expired_out = r.expired;

    default clocking @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);

    a_start_clears: assert property (start_in |=> !expired_out)
        else $error("Delay timer not restarted by start.");
    a_code_units: assert property (start_in && code_in == 3'h3 |=> r.units == 5'h08)
        else $error("Delay code 3 did not load eight units.");

endmodule

// >>> ovf_host_model.sv
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
// Command side of the board host. Strobes are single-cycle pulses launched just after an edge.
module ovf_host_model (
    input wire logic clk_in,
    input wire logic [15:0] rd_data_in,
    output logic cmd_wr_out,
    output logic cmd_rd_out,
    output logic [7:0] cmd_code_out,
    output logic [15:0] cmd_data_out,
    output logic status_clear_out,
    output logic clear_faults_out
);
    initial begin
        cmd_wr_out = 1'b0;
        cmd_rd_out = 1'b0;
        cmd_code_out = 8'h00;
        cmd_data_out = 16'h0000;
        status_clear_out = 1'b0;
        clear_faults_out = 1'b0;
    end

    task automatic wr(input logic [7:0] code, input logic [15:0] data);
        @(posedge clk_in);
        #1;
        cmd_code_out = code;
        cmd_data_out = data;
        cmd_wr_out = 1'b1;
        @(posedge clk_in);
        #1;
        cmd_wr_out = 1'b0;
        // Stale data is scrambled so the design cannot lean on it.
        cmd_data_out = ~data;
    endtask

    task automatic rd(input logic [7:0] code, output logic [15:0] data);
        @(posedge clk_in);
        #1;
        cmd_code_out = code;
        cmd_rd_out = 1'b1;
        @(posedge clk_in);
        #1;
        cmd_rd_out = 1'b0;
        @(posedge clk_in);
        #1;
        data = rd_data_in;
    endtask

    task automatic clr(input logic all);
        @(posedge clk_in);
        #1;
        status_clear_out = !all;
        clear_faults_out = all;
        @(posedge clk_in);
        #1;
        status_clear_out = 1'b0;
        clear_faults_out = 1'b0;
    endtask
endmodule

// >>> ovf_fault_response_test.sv
`timescale 1ns/100ps

module ovf_fault_response_test
    import ovf_pkg::*;
;
    // A short delay unit keeps the longest run-on at 64 cycles.
    localparam logic [15:0] UNIT = 16'h0004;
    typedef struct {logic [7:0] code; logic [15:0] data; logic [15:0] exp;} ovf_row_t;
    ovf_row_t rows [4] = '{'{8'h40, 16'h1234, 16'h1234}, '{8'h41, 16'hABCD, 16'h00CD},
                           '{8'h55, 16'h5A5A, 16'h0000}, '{8'h40, 16'h0000, 16'h0000}};
    logic [15:0] rt [3] = '{16'h0088, 16'h0098, 16'h00B8};
    logic clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic [15:0] vout_meas_in = 16'h0000;
    logic output_on_in = 1'b1;
    logic cmd_wr_in;
    logic cmd_rd_in;
    logic status_clear_in;
    logic clear_faults_in;
    logic [7:0] cmd_code_in;
    logic [15:0] cmd_data_in;
    logic [15:0] rd_data_out;
    logic [15:0] rd_val;
    logic output_enable_out;
    logic fault_latched_out;
    int failures = 0;
    int num_checks = 0;
    int cycles = 0;
    int highs;

    ovf_fault_response #(.UNIT_CYCLES(UNIT)) i_ovf_fault_response (
        .clk_in(clk_in), .sys_rst_in(sys_rst_in), .cmd_wr_in(cmd_wr_in), .cmd_rd_in(cmd_rd_in),
        .cmd_code_in(cmd_code_in), .cmd_data_in(cmd_data_in), .vout_meas_in(vout_meas_in),
        .output_on_in(output_on_in), .status_clear_in(status_clear_in), .clear_faults_in(clear_faults_in),
        .rd_data_out(rd_data_out), .output_enable_out(output_enable_out), .fault_latched_out(fault_latched_out));

    ovf_host_model i_ovf_host_model (
        .clk_in(clk_in), .rd_data_in(rd_data_out), .cmd_wr_out(cmd_wr_in), .cmd_rd_out(cmd_rd_in),
        .cmd_code_out(cmd_code_in), .cmd_data_out(cmd_data_in), .status_clear_out(status_clear_in),
        .clear_faults_out(clear_faults_in));

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        forever #20 clk_in = ~clk_in;
    end

    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            finish_test();
        end
    end

    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask

    // Counts restarts, that is rising edges of the output enable, over n cycles.
    task automatic cnt(input int n);
        logic prev;
        highs = 0;
        prev = output_enable_out;
        repeat (n) begin
            cyc(1);
            if (output_enable_out === 1'b1 && prev !== 1'b1) highs++;
            prev = output_enable_out;
        end
    endtask

    task automatic finish_test();
        $display("Checks %0d, failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        cyc(1);
        chk("reset_state", 16'({fault_latched_out, output_enable_out}), 16'h0000);
        cyc(11);
        sys_rst_in = 1'b0;
        i_ovf_host_model.rd(8'h40, rd_val);
        chk("thresh_reset", rd_val, 16'hFFFF);
        i_ovf_host_model.rd(8'h41, rd_val);
        chk("react_reset", rd_val, 16'h0080);
        foreach (rows[i]) begin
            i_ovf_host_model.wr(rows[i].code, rows[i].data);
            i_ovf_host_model.rd(rows[i].code, rd_val);
            chk("reg_readback", rd_val, rows[i].exp);
        end
        i_ovf_host_model.wr(8'h40, 16'h0100);
        i_ovf_host_model.wr(8'h41, 16'h0000);
        vout_meas_in = 16'h0100;
        cyc(3);
        chk("equal_no_fault", 16'(fault_latched_out), 16'h0000);
        vout_meas_in = 16'h0101;
        cyc(20);
        chk("ignore_fault", 16'({fault_latched_out, output_enable_out}), 16'h0001);
        // Shutdown with no retry; then status clear, clear-all and off-then-on clear the latch in turn.
        i_ovf_host_model.wr(8'h41, 16'h0080);
        for (int k = 0; k < 3; k++) begin
            vout_meas_in = 16'h0101;
            cyc(3);
            chk("shut_off", 16'({fault_latched_out, output_enable_out}), 16'h0002);
            vout_meas_in = 16'h0000;
            cyc(40);
            chk("no_retry_off", 16'({fault_latched_out, output_enable_out}), 16'h0002);
            if (k < 2) begin
                i_ovf_host_model.clr(k[0]);
            end else begin
                output_on_in = 1'b0;
                cyc(2);
                output_on_in = 1'b1;
            end
            cyc(4);
            chk("cleared", 16'({fault_latched_out, output_enable_out}), 16'h0001);
        end
        i_ovf_host_model.wr(8'h41, 16'h00C0);
        vout_meas_in = 16'h0101;
        cyc(3);
        chk("holdoff_off", 16'(output_enable_out), 16'h0000);
        vout_meas_in = 16'h0000;
        cyc(2);
        chk("holdoff_resume", 16'({fault_latched_out, output_enable_out}), 16'h0003);
        i_ovf_host_model.clr(1'b1);
        // Run-on with every delay code; codes above the last defined one give the longest delay.
        for (int d = 0; d < 8; d++) begin
            i_ovf_host_model.wr(8'h41, 16'h0040 | 16'(d));
            vout_meas_in = 16'h0101;
            cyc(int'(UNIT) * (1 << ((d > 4) ? 4 : d)) - 2);
            chk("runon_on", 16'({fault_latched_out, output_enable_out}), 16'h0003);
            cyc(6);
            chk("runon_off", 16'(output_enable_out), 16'h0000);
            vout_meas_in = 16'h0000;
            i_ovf_host_model.clr(1'b1);
            cyc(3);
        end
        // One and three retries, then endless retries, against a fault that never goes.
        foreach (rt[i]) begin
            i_ovf_host_model.wr(8'h41, rt[i]);
            vout_meas_in = 16'h0101;
            cyc(3);
            cnt(40);
            if (i < 2) begin
                chk("retry_count", 16'(highs), 16'(rt[i][5:3]));
            end else begin
                chk("retry_first", 16'(highs != 0), 16'h0001);
            end
            cnt(40);
            chk("retry_later", 16'(highs != 0), 16'(i == 2));
            chk("retry_latch", 16'(fault_latched_out), 16'h0001);
            vout_meas_in = 16'h0000;
            i_ovf_host_model.clr(1'b1);
            cyc(3);
        end
        // A reset in mid-run drops a latched fault and restores the reaction setting.
        i_ovf_host_model.wr(8'h41, 16'h0080);
        vout_meas_in = 16'h0101;
        cyc(3);
        sys_rst_in = 1'b1;
        cyc(2);
        chk("mid_reset", 16'({fault_latched_out, output_enable_out}), 16'h0000);
        sys_rst_in = 1'b0;
        cyc(2);
        chk("after_reset", 16'({fault_latched_out, output_enable_out}), 16'h0001);
        i_ovf_host_model.rd(8'h41, rd_val);
        chk("react_after_reset", rd_val, 16'h0080);
        finish_test();
    end
endmodule
